// ==== verilog/ebu_pkg.sv ====
// external bus unit: shared constants, carrier types and operation summary
// Operation
// RQ1: single chip mode refuses external accesses; four mux/width bus types otherwise
// RQ2: demultiplexed: address on address-only port, data on shared port or low byte
// RQ3: multiplexed: address phase and data phase both on the shared port
// RQ4: cycle wait, tri-state time, latch strobe length, strobe delay are programmable
// RQ5: four independent windows, each with range select and bus configuration
// RQ6: overlapping windows: four beats three, two beats one
// RQ7: addresses outside all windows use the default bus configuration
// RQ8: five chip selects, one per window plus default region
// RQ9: ready input stretches a cycle, enabled per window
// RQ10: arbitration enable hands request, grant and hold pins to the controller
// RQ11: after reset the controller is arbitration master, grant pin an output
// RQ12: grant pin direction bit set makes slave mode, grant becomes input
// RQ13: address space restrictable to 1 MByte, 256 KBytes or 64 KBytes
// RQ14: segment lines: eight for 16 MBytes, then four, two or none
// RQ15: by default chip selects change one step after latch strobe rises
// RQ16: select timing bit set: chip selects change with latch strobe rise
// RQ17: ready active level comes from each window's polarity bit
// RQ18: a ready-enabled device ends each cycle with ready at that level
// RQ19: on hold request finish cycle, float bus, grant; resume after release
// RQ20: compare address to enabled windows, pick winner, apply its settings
package ebu_pkg;
    localparam int          ADDR_W      = 24;
    localparam int          DATA_W      = 16;
    localparam int          NUM_WIN     = 4;
    localparam int          NUM_CS      = 5;
    // --------
    // bus type field: bit 1 multiplexed, bit 0 byte wide
    // --------
    localparam int          BT_MUX_BIT  = 1;
    localparam int          BT_8BIT_BIT = 0;
    // --------
    // address space codes
    // --------
    localparam logic [1:0]  SP_16M      = 2'h0;
    localparam logic [1:0]  SP_1M       = 2'h1;
    localparam logic [1:0]  SP_256K     = 2'h2;
    localparam logic [1:0]  SP_64K      = 2'h3;
    localparam logic [7:0]  SEG_16M     = 8'hFF;
    localparam logic [7:0]  SEG_1M      = 8'h0F;
    localparam logic [7:0]  SEG_256K    = 8'h03;
    localparam logic [7:0]  SEG_64K     = 8'h00;
    // --------
    // reset values and timing counts
    // --------
    localparam logic [2:0]  WIN_DEFAULT = 3'h0;
    localparam logic [4:0]  CS_IDLE     = 5'h1F;
    localparam logic [15:0] MASK_WORD   = 16'hFFFF;
    localparam logic [15:0] MASK_BYTE   = 16'h00FF;
    localparam logic [3:0]  CNT_ZERO    = 4'h0;
    localparam logic [3:0]  CNT_EXT     = 4'h1;
    // --------
    // carrier types
    // --------
    typedef struct packed {
        logic        enable;
        logic [11:0] base;
        logic [3:0]  size;
    } ebu_range_type;

    typedef struct packed {
        logic [1:0]  bus_type;
        logic [3:0]  wait_cnt;
        logic        tri_ext;
        logic        ale_ext;
        logic        rw_dly;
        logic        rdy_en;
        logic        rdy_pol;
        logic        cs_en;
    } ebu_bus_cfg_type;

    typedef enum logic [5:0] {
        ST_IDLE = 6'b000001,
        ST_ALE  = 6'b000010,
        ST_DLY  = 6'b000100,
        ST_STRB = 6'b001000,
        ST_TRI  = 6'b010000,
        ST_HOLD = 6'b100000
    } ebu_state_type;
endpackage

// ==== verilog/ebu_window_match.sv ====
// address window decoder with fixed precedence
`timescale 1ns/1ps
`default_nettype none
module ebu_window_match
    import ebu_pkg::*;
#(
    parameter int NWIN = NUM_WIN
) (
    input  wire logic [ADDR_W-1:0]           addr,
    input  wire ebu_range_type [NWIN-1:0]    ranges,
    output logic [NWIN-1:0]                  hit,
    output logic [2:0]                       sel
);
    // ----------------------------------------
    // range compare
    // ----------------------------------------
    function automatic logic win_hit(input ebu_range_type r, input logic [ADDR_W-1:0] a);
        logic [11:0] diff;
        diff = a[ADDR_W-1:12] ^ r.base;
        win_hit = r.enable && ((diff >> r.size) == 12'h000);
    endfunction

    always_comb begin
        for (int i = 0; i < NWIN; i++) begin
            hit[i] = win_hit(ranges[i], addr); // [RQ5] [RQ20]
        end
    end

    // ----------------------------------------
    // precedence: higher window wins
    // ----------------------------------------
    always_comb begin
        sel = WIN_DEFAULT; // [RQ7]
        for (int i = 0; i < NWIN; i++) begin
            if (hit[i]) begin
                sel = 3'(i + 1); // [RQ6]
            end
        end
    end
endmodule
`default_nettype wire

// ==== verilog/ebu_top.sv ====
// external bus unit: bus cycle sequencer, pins and arbitration
`timescale 1ns/1ps
`default_nettype none
module ebu_top
    import ebu_pkg::*;
(
    input  wire logic                          clock,
    input  wire logic                          rst_b,
    input  wire logic                          req_valid,
    input  wire logic [ADDR_W-1:0]             req_addr,
    input  wire logic                          req_write,
    input  wire logic [DATA_W-1:0]             req_wdata,
    output logic                               req_ready,
    output logic                               rsp_valid,
    output logic                               rsp_error,
    output logic [DATA_W-1:0]                  rsp_rdata,
    input  wire logic                          single_chip,
    input  wire logic [1:0]                    addr_space,
    input  wire logic                          select_timing_config,
    input  wire logic                          arbitration_enable,
    input  wire logic                          grant_pin_direction_bit,
    input  wire ebu_range_type [NUM_WIN-1:0]   window_range_select,
    input  wire ebu_bus_cfg_type [NUM_WIN-1:0] bus_window_config,
    input  wire ebu_bus_cfg_type               default_bus_config,
    input  wire logic [DATA_W-1:0]             shared_ad_port_in,
    output logic [DATA_W-1:0]                  shared_ad_port_out,
    output logic [DATA_W-1:0]                  shared_ad_port_oe,
    output logic [DATA_W-1:0]                  address_only_port_out,
    output logic                               address_only_port_oe,
    output logic [7:0]                         segment_addr_out,
    output logic                               addr_latch_en,
    output logic                               read_strobe_b,
    output logic                               write_strobe_b,
    output logic                               strobe_oe,
    output logic [NUM_CS-1:0]                  chip_select_lines_b,
    input  wire logic                          ready_in,
    input  wire logic                          hold_req_b,
    input  wire logic                          takeover_grant_in,
    output logic                               takeover_grant_out,
    output logic                               takeover_grant_oe,
    output logic                               ownership_request_out_b
);
    // ----------------------------------------
    // declarations
    // ----------------------------------------
    ebu_state_type         state_r, state_nxt;
    ebu_bus_cfg_type       cfg_r, cfg_sel;
    logic [3:0]            cnt_r;
    logic [2:0]            win_r, win_sel;
    logic [NUM_WIN-1:0]    win_hit;
    logic                  pend_r, pend_nxt, write_r, cs_late_r;
    logic [ADDR_W-1:0]     addr_r;
    logic [DATA_W-1:0]     wdata_r;
    logic [NUM_CS-1:0]     cs_pend_r, cs_sel;
    logic                  start, finish, refuse, go_hold, leave_hold;
    logic                  enter_strb, rdy_ok, own, slave, master_hold, accept;

    function automatic logic [7:0] seg_mask(input logic [1:0] sp);
        if (sp == SP_16M) begin
            seg_mask = SEG_16M;
        end else if (sp == SP_1M) begin
            seg_mask = SEG_1M;
        end else if (sp == SP_256K) begin
            seg_mask = SEG_256K;
        end else begin
            seg_mask = SEG_64K;
        end
    endfunction

    // ----------------------------------------
    // window selection
    // ----------------------------------------
    ebu_window_match #(.NWIN(NUM_WIN)) u_match (
        .addr   (addr_r),
        .ranges (window_range_select),
        .hit    (win_hit),
        .sel    (win_sel)
    );

    always_comb begin
        cfg_sel = default_bus_config; // [RQ7]
        if (win_sel != WIN_DEFAULT) begin
            cfg_sel = bus_window_config[win_sel - 3'h1]; // [RQ20]
        end
        cs_sel = cfg_sel.cs_en ? ~(5'h01 << win_sel) : CS_IDLE; // [RQ8]
    end

    // ----------------------------------------
    // sequencer decisions
    // ----------------------------------------
    assign slave       = arbitration_enable && grant_pin_direction_bit; // [RQ12]
    assign own         = !slave || !takeover_grant_in;
    assign master_hold = arbitration_enable && !grant_pin_direction_bit && !hold_req_b; // [RQ10]
    assign rdy_ok      = !cfg_r.rdy_en || (ready_in == cfg_r.rdy_pol); // [RQ9] [RQ17] [RQ18]
    assign enter_strb  = (state_r == ST_DLY) ||
                         (state_r == ST_ALE && cnt_r == CNT_ZERO && !cfg_r.rw_dly);
    assign accept      = req_valid && req_ready;

    always_comb begin
        state_nxt  = state_r;
        start      = 1'b0;
        finish     = 1'b0;
        refuse     = 1'b0;
        go_hold    = 1'b0;
        leave_hold = 1'b0;
        case (state_r)
            ST_IDLE: begin
                if (pend_r && single_chip) begin
                    refuse = 1'b1; // [RQ1]
                end else if (master_hold) begin
                    go_hold   = 1'b1; // [RQ19]
                    state_nxt = ST_HOLD;
                end else if (pend_r && own) begin
                    start     = 1'b1;
                    state_nxt = ST_ALE;
                end
            end
            ST_ALE: begin
                if (cnt_r == CNT_ZERO) begin
                    state_nxt = cfg_r.rw_dly ? ST_DLY : ST_STRB; // [RQ4]
                end
            end
            ST_DLY: state_nxt = ST_STRB;
            ST_STRB: begin
                if (cnt_r == CNT_ZERO && rdy_ok) begin
                    finish    = 1'b1;
                    state_nxt = ST_TRI;
                end
            end
            ST_TRI: begin
                if (cnt_r == CNT_ZERO) begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_HOLD: begin
                if (hold_req_b || !arbitration_enable) begin
                    leave_hold = 1'b1; // [RQ19]
                    state_nxt  = ST_IDLE;
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    // ----------------------------------------
    // state, counter and latched configuration
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            state_r <= ST_IDLE;
            cnt_r   <= CNT_ZERO;
            cfg_r   <= '0;
            win_r   <= WIN_DEFAULT;
        end else begin
            state_r <= state_nxt;
            if (start) begin
                cfg_r <= cfg_sel; // [RQ20]
                win_r <= win_sel;
                cnt_r <= cfg_sel.ale_ext ? CNT_EXT : CNT_ZERO; // [RQ4]
            end else if (enter_strb) begin
                cnt_r <= cfg_r.wait_cnt; // [RQ4]
            end else if (finish) begin
                cnt_r <= cfg_r.tri_ext ? CNT_EXT : CNT_ZERO; // [RQ4]
            end else if (cnt_r != CNT_ZERO) begin
                cnt_r <= cnt_r - 4'h1;
            end
        end
    end

    // ----------------------------------------
    // request side
    // ----------------------------------------
    assign pend_nxt = (pend_r && !(start || refuse)) || accept;

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            pend_r    <= 1'b0;
            req_ready <= 1'b0;
            addr_r    <= '0;
            write_r   <= 1'b0;
            wdata_r   <= '0;
            rsp_valid <= 1'b0;
            rsp_error <= 1'b0;
            rsp_rdata <= '0;
        end else begin
            pend_r    <= pend_nxt;
            req_ready <= !pend_nxt && (state_nxt == ST_IDLE);
            if (accept) begin
                addr_r  <= req_addr & {seg_mask(addr_space), MASK_WORD}; // [RQ13]
                write_r <= req_write;
                wdata_r <= req_wdata;
            end
            rsp_valid <= finish || refuse;
            rsp_error <= refuse; // [RQ1]
            if (finish && !write_r) begin
                rsp_rdata <= cfg_r.bus_type[BT_8BIT_BIT] ?
                             (shared_ad_port_in & MASK_BYTE) : shared_ad_port_in; // [RQ2]
            end
        end
    end

    // ----------------------------------------
    // bus pins
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            addr_latch_en         <= 1'b0;
            read_strobe_b         <= 1'b1;
            write_strobe_b        <= 1'b1;
            chip_select_lines_b   <= CS_IDLE;
            cs_pend_r             <= CS_IDLE;
            cs_late_r             <= 1'b0;
            shared_ad_port_out    <= '0;
            shared_ad_port_oe     <= '0;
            address_only_port_out <= '0;
            address_only_port_oe  <= 1'b0;
            segment_addr_out      <= '0;
        end else begin
            cs_late_r <= start && !select_timing_config;
            if (start) begin
                addr_latch_en         <= 1'b1;
                shared_ad_port_out    <= addr_r[DATA_W-1:0];
                shared_ad_port_oe     <= cfg_sel.bus_type[BT_MUX_BIT] ? MASK_WORD : '0; // [RQ3]
                address_only_port_out <= addr_r[DATA_W-1:0];
                address_only_port_oe  <= !cfg_sel.bus_type[BT_MUX_BIT]; // [RQ2]
                segment_addr_out      <= addr_r[ADDR_W-1:DATA_W]; // [RQ14]
                cs_pend_r             <= cs_sel;
                if (select_timing_config) begin
                    chip_select_lines_b <= cs_sel; // [RQ16]
                end
            end
            if (cs_late_r) begin
                chip_select_lines_b <= cs_pend_r; // [RQ15]
            end
            if (state_r == ST_ALE && cnt_r == CNT_ZERO) begin
                addr_latch_en <= 1'b0;
            end
            if (enter_strb) begin
                if (write_r) begin
                    write_strobe_b     <= 1'b0;
                    shared_ad_port_out <= wdata_r;
                    shared_ad_port_oe  <= cfg_r.bus_type[BT_8BIT_BIT] ? MASK_BYTE : MASK_WORD;
                end else begin
                    read_strobe_b      <= 1'b0;
                    shared_ad_port_oe  <= '0;
                end
            end
            if (finish) begin
                read_strobe_b       <= 1'b1;
                write_strobe_b      <= 1'b1;
                shared_ad_port_oe   <= '0;
                chip_select_lines_b <= CS_IDLE;
            end
            if (state_r == ST_TRI && state_nxt == ST_IDLE) begin
                address_only_port_oe <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // arbitration pins
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            takeover_grant_out      <= 1'b1;
            takeover_grant_oe       <= 1'b1; // [RQ11]
            ownership_request_out_b <= 1'b1;
            strobe_oe               <= 1'b1;
        end else begin
            takeover_grant_oe <= !grant_pin_direction_bit; // [RQ11] [RQ12]
            if (go_hold) begin
                takeover_grant_out <= 1'b0; // [RQ19]
            end else if (leave_hold) begin
                takeover_grant_out <= 1'b1;
            end
            if (slave) begin
                ownership_request_out_b <= !(pend_r || state_r != ST_IDLE); // [RQ10]
            end else begin
                ownership_request_out_b <= !(arbitration_enable && state_r == ST_HOLD &&
                                             (pend_r || req_valid)); // [RQ10]
            end
            strobe_oe <= (state_nxt != ST_HOLD) && (own || state_r != ST_IDLE); // [RQ19]
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    sequence ale_rise_s;
        $rose(addr_latch_en);
    endsequence

    sequence cs_late_s;
        (chip_select_lines_b == CS_IDLE) ##1 (chip_select_lines_b == cs_pend_r);
    endsequence

    single_chip_a: assert property ((state_r == ST_IDLE && pend_r && single_chip)
        |=> (rsp_error && rsp_valid && !addr_latch_en)) // [RQ1]
        else $error("single chip access reached the bus");
    demux_addr_a: assert property ((addr_latch_en && !cfg_r.bus_type[BT_MUX_BIT])
        |-> (address_only_port_oe && address_only_port_out == addr_r[DATA_W-1:0])) // [RQ2]
        else $error("demultiplexed address missing");
    mux_addr_a: assert property ((addr_latch_en && cfg_r.bus_type[BT_MUX_BIT])
        |-> (shared_ad_port_oe == MASK_WORD && shared_ad_port_out == addr_r[DATA_W-1:0])) // [RQ3]
        else $error("multiplexed address missing");
    wait_len_a: assert property ((state_r == ST_STRB && cnt_r != CNT_ZERO)
        |=> (state_r == ST_STRB && cnt_r == $past(cnt_r) - 4'h1)) // [RQ4]
        else $error("wait count cut short");
    window_prio_a: assert property ((state_r == ST_IDLE && win_hit[3])
        |-> (win_sel == 3'h4 && cfg_sel == bus_window_config[3])) // [RQ6]
        else $error("window four lost precedence");
    default_win_a: assert property ((start && win_hit == '0)
        |=> (win_r == WIN_DEFAULT && cfg_r == $past(default_bus_config))) // [RQ7]
        else $error("default configuration not used");
    ready_wait_a: assert property ((state_r == ST_STRB && cnt_r == CNT_ZERO && cfg_r.rdy_en
        && ready_in != cfg_r.rdy_pol) |=> (state_r == ST_STRB && !(read_strobe_b
        && write_strobe_b))) // [RQ9]
        else $error("cycle ended without ready");
    cs_timing_a: assert property ((start && select_timing_config) // [RQ16]
        |=> ale_rise_s ##0 (chip_select_lines_b == cs_pend_r))
        else $error("chip select timing wrong");
    cs_late_a: assert property ((start && !select_timing_config) |=> cs_late_s) // [RQ15]
        else $error("delayed chip select wrong");
    hold_float_a: assert property ((state_r == ST_HOLD)
        |-> (!takeover_grant_out && shared_ad_port_oe == '0 && !strobe_oe)) // [RQ19]
        else $error("bus not floated in hold");
    grant_dir_a: assert property (grant_pin_direction_bit |=> !takeover_grant_oe) // [RQ12]
        else $error("grant pin driven in slave mode");
endmodule
`default_nettype wire

// ==== test/ebu_ext_mem.sv ====
// external memory model with ready answer
`timescale 1ns/1ps
`default_nettype none
module ebu_ext_mem
    import ebu_pkg::*;
(
    input  wire logic              clock,
    input  wire logic [DATA_W-1:0] shared_ad_port_out,
    input  wire logic [DATA_W-1:0] shared_ad_port_oe,
    input  wire logic [DATA_W-1:0] address_only_port_out,
    input  wire logic              addr_latch_en,
    input  wire logic              read_strobe_b,
    input  wire logic              write_strobe_b,
    input  wire logic [3:0]        rdy_lat,
    input  wire logic              rdy_pol,
    output logic [DATA_W-1:0]      shared_ad_port_in,
    output logic                   ready_in
);
    logic [DATA_W-1:0] mem_r [16];
    logic [DATA_W-1:0] last_r = 16'h0000;
    logic [3:0]        idx_r  = 4'h0;
    logic [3:0]        cnt_r  = 4'h0;
    always @(posedge clock) begin
        if (addr_latch_en) begin
            idx_r <= (|shared_ad_port_oe) ? shared_ad_port_out[4:1] : address_only_port_out[4:1];
        end
        if (!write_strobe_b) begin
            mem_r[idx_r] <= shared_ad_port_out & shared_ad_port_oe;
        end
        cnt_r  <= (read_strobe_b && write_strobe_b) ? 4'h0 : cnt_r + 4'h1;
        last_r <= shared_ad_port_in;
    end
    // ready held off until the latency has run, opposite level before
    assign ready_in = (cnt_r >= rdy_lat) ? rdy_pol : !rdy_pol;
    // released data lines show the inverse of the last value
    assign shared_ad_port_in = !read_strobe_b ? mem_r[idx_r] : ~last_r;
endmodule
`default_nettype wire

// ==== test/tb_ebu_top.sv ====
// bench for the external bus unit
`timescale 1ns/1ps
`default_nettype none
module tb_ebu_top
    import ebu_pkg::*;
;
    logic                          clock, rst_b, req_valid, req_write, req_ready, rsp_valid;
    logic                          rsp_error, single_chip, select_timing_config, got_err;
    logic                          arbitration_enable, grant_pin_direction_bit, addr_latch_en;
    logic                          read_strobe_b, write_strobe_b, strobe_oe, ready_in, hold_req_b;
    logic                          takeover_grant_in, takeover_grant_out, takeover_grant_oe;
    logic                          ownership_request_out_b, rdy_pol, ale_seen, cs_early, ao_seen;
    logic                          mux_seen, address_only_port_oe;
    logic [1:0]                    addr_space;
    logic [3:0]                    rdy_lat;
    logic [7:0]                    segment_addr_out, seg_or;
    logic [NUM_CS-1:0]             chip_select_lines_b, cs_min;
    logic [ADDR_W-1:0]             req_addr;
    logic [DATA_W-1:0]             req_wdata, rsp_rdata, shared_ad_port_in, shared_ad_port_out;
    logic [DATA_W-1:0]             shared_ad_port_oe, address_only_port_out, oe_or, got_data, mask;
    ebu_range_type [NUM_WIN-1:0]   window_range_select;
    ebu_bus_cfg_type [NUM_WIN-1:0] bus_window_config;
    ebu_bus_cfg_type               default_bus_config, cfg;
    int                            mismatches = 0, checked = 0, cyc, base;
    logic [7:0]                    segm [4] = '{SEG_16M, SEG_1M, SEG_256K, SEG_64K};
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic [2:0]        win;
        logic [NUM_CS-1:0] cs_b;
    } ebu_row_type;
    ebu_row_type rows [5] = '{'{24'h000002, 16'hA55A, 3'h0, 5'h1E},
        '{24'h011004, 16'h1234, 3'h1, 5'h1D}, '{24'h010006, 16'hBEEF, 3'h2, 5'h1B},
        '{24'h020008, 16'hC3C3, 3'h3, 5'h17}, '{24'h02100A, 16'h7E81, 3'h4, 5'h0F}};
    ebu_top DUT (.clock, .rst_b, .req_valid, .req_addr, .req_write, .req_wdata, .req_ready,
        .rsp_valid, .rsp_error, .rsp_rdata, .single_chip, .addr_space, .select_timing_config,
        .arbitration_enable, .grant_pin_direction_bit, .window_range_select, .bus_window_config,
        .default_bus_config, .shared_ad_port_in, .shared_ad_port_out, .shared_ad_port_oe,
        .address_only_port_out, .address_only_port_oe, .segment_addr_out, .addr_latch_en,
        .read_strobe_b, .write_strobe_b, .strobe_oe, .chip_select_lines_b, .ready_in, .hold_req_b,
        .takeover_grant_in, .takeover_grant_out, .takeover_grant_oe, .ownership_request_out_b);
    ebu_ext_mem MEM (.clock, .shared_ad_port_out, .shared_ad_port_oe, .address_only_port_out,
        .addr_latch_en, .read_strobe_b, .write_strobe_b, .rdy_lat, .rdy_pol, .shared_ad_port_in,
        .ready_in);
    // --------
    // pin monitor and shared tasks
    // --------
    always @(posedge clock) begin
        if (addr_latch_en) begin
            ale_seen <= 1'h1;
            cs_early <= cs_early | (chip_select_lines_b != CS_IDLE);
            ao_seen  <= ao_seen | address_only_port_oe;
            mux_seen <= mux_seen | (|shared_ad_port_oe);
            seg_or   <= seg_or | segment_addr_out;
        end
        cs_min <= cs_min & chip_select_lines_b;
        oe_or  <= write_strobe_b ? oe_or : (oe_or | shared_ad_port_oe);
    end
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic do_op(input logic [ADDR_W-1:0] a, input logic w, input logic [DATA_W-1:0] d);
        int n;
        n = 0;
        {ale_seen, cs_early, ao_seen, mux_seen, cs_min, seg_or, oe_or} = {4'h0, CS_IDLE, 24'h0};
        {req_addr, req_write, req_wdata, req_valid} = {a, w, d, 1'h1};
        while (req_ready !== 1'h1 && n < 300) begin
            @(posedge clock);
            #1 n++;
        end
        @(posedge clock);
        #1 req_valid = 1'h0;
        cyc = 0;
        while (rsp_valid !== 1'h1 && cyc < 300) begin
            @(posedge clock);
            #1 cyc++;
        end
        {got_err, got_data} = {rsp_error, rsp_rdata};
        chk("rsp_valid", 1'h1, rsp_valid);
    endtask
    task print_verdict;
        if (mismatches == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // --------
    // clock and watchdog
    // --------
    initial begin
        clock = 1'h0;
        forever #4 clock = ~clock;
    end
    initial begin
        repeat (20000) @(posedge clock);
        mismatches++;
        print_verdict();
    end
    // --------
    // window table, then awkward cases
    // --------
    initial begin
        {rst_b, req_valid, req_write, single_chip, select_timing_config} = 5'h00;
        {arbitration_enable, grant_pin_direction_bit, hold_req_b, takeover_grant_in} = 4'h3;
        {req_addr, req_wdata, addr_space, rdy_lat, rdy_pol} = {40'h0, SP_16M, 4'h3, 1'h1};
        window_range_select = {17'h10210, 17'h10201, 17'h10100, 17'h10101};
        bus_window_config = {12'h007, 12'hC81, 12'h429, 12'h851};
        default_bus_config = 12'h001;
        repeat (10) @(posedge clock);
        #1 rst_b = 1'h1;
        chk("reset_pins", {5'h0F, CS_IDLE}, {addr_latch_en, strobe_oe, takeover_grant_oe,
            takeover_grant_out, ownership_request_out_b, chip_select_lines_b});
        foreach (rows[i]) begin
            cfg = rows[i].win ? bus_window_config[rows[i].win - 3'h1] : default_bus_config;
            mask = cfg.bus_type[BT_8BIT_BIT] ? MASK_BYTE : MASK_WORD;
            base = 3 + cfg.ale_ext + cfg.rw_dly + cfg.wait_cnt;
            do_op(rows[i].addr, 1'h1, rows[i].wdata);
            chk("select", rows[i].cs_b, cs_min);
            chk("lanes", mask, oe_or);
            do_op(rows[i].addr, 1'h0, 16'h0000);
            chk("rdata", rows[i].wdata & mask, got_data);
            chk("phase", {2{cfg.bus_type[BT_MUX_BIT]}} ^ 2'h2, {ao_seen, mux_seen});
            chk("cs_late", 1'h0, cs_early & !cfg.ale_ext);
            chk("cycles", 1'h1, cyc >= base + cfg.rdy_en &&
                cyc <= base + 4 * cfg.rdy_en);
        end
        {bus_window_config[3].rdy_pol, rdy_pol} = 2'h0;
        do_op(rows[4].addr, 1'h0, 16'h0000);
        chk("rdy_low", {1'h1, rows[4].wdata}, {cyc > 4 && cyc <= 8, got_data});
        select_timing_config = 1'h1;
        do_op(rows[0].addr, 1'h0, 16'h0000);
        chk("cs_early", 1'h1, cs_early);
        select_timing_config = 1'h0;
        for (int s = 0; s < 4; s++) begin
            addr_space = s[1:0];
            do_op(24'hAB0002, 1'h0, 16'h0000);
            chk("segment", 8'hAB & segm[s], seg_or);
        end
        single_chip = 1'h1;
        do_op(rows[1].addr, 1'h1, 16'h0000);
        chk("single", {1'h1, 1'h0, 8'h01}, {got_err, ale_seen, cyc[7:0]});
        {single_chip, arbitration_enable, hold_req_b} = 3'h2;
        repeat (2) @(posedge clock);
        #1 chk("hold_grant", 2'h0, {takeover_grant_out, strobe_oe});
        fork begin
            repeat (10) @(posedge clock);
            #1 chk("hold_wait", 2'h0, {ale_seen, ownership_request_out_b});
            hold_req_b = 1'h1;
        end join_none
        do_op(rows[0].addr, 1'h0, 16'h0000);
        chk("hold_end", {2'h3, rows[0].wdata}, {takeover_grant_out, strobe_oe, got_data});
        grant_pin_direction_bit = 1'h1;
        repeat (2) @(posedge clock);
        #1 chk("slave_dir", 1'h0, takeover_grant_oe);
        fork begin
            repeat (10) @(posedge clock);
            #1 chk("slave_wait", 2'h0, {ale_seen, ownership_request_out_b});
            takeover_grant_in = 1'h0;
        end join_none
        do_op(rows[1].addr, 1'h0, 16'h0000);
        chk("slave_data", rows[1].wdata, got_data);
        print_verdict();
    end
endmodule
`default_nettype wire
